// >>> logic/flash_ctrl_pkg.sv
// Constants, types and state layout for the flash array control block
package flash_ctrl_pkg;

  // ==========================================================================
  // CPU address map (register indices; bus byte address is four times these)
  localparam logic [15:0] ARRAY_LO      = 16'h8000;
  localparam logic [15:0] ARRAY_USER_HI = 16'hFDFF;
  localparam logic [15:0] PROTECT_LO    = 16'hFF80;
  localparam logic [15:0] PROTECT_HI    = 16'hFF81;
  localparam logic [15:0] CTRL_INDEX    = 16'hFE0B;
  localparam logic [15:0] VECTOR_LO     = 16'hFFCC;
  localparam logic [15:0] VECTOR_HI     = 16'hFFFF;

  // ==========================================================================
  // Control register fields and reset value
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         PGM_BIT     = 0;
  localparam int         ERASE_BIT   = 1;
  localparam int         MARGIN_BIT  = 2;
  localparam int         HIGH_VOLT_ENABLE_BIT    = 3;
  localparam int         BLK_LSB     = 4;
  localparam int         DIV_LSB     = 6;

  // ==========================================================================
  // Erase and program region masks over array address A14..A0
  localparam logic [14:0] MASK_FULL  = 15'h0000;
  localparam logic [14:0] MASK_HALF  = 15'h4000;
  localparam logic [14:0] MASK_EIGHT = 15'h7E00;
  localparam logic [14:0] MASK_ROW   = 15'h7FC0;
  localparam logic [14:0] MASK_PAGE  = 15'h7FF8;

  // Start of the range locked by each block-protect bit, to the array top
  localparam logic [14:0] PROT_START0 = 15'h0000;
  localparam logic [14:0] PROT_START1 = 15'h1000;
  localparam logic [14:0] PROT_START2 = 15'h2000;
  localparam logic [14:0] PROT_START3 = 15'h4000;

  // ==========================================================================
  // Timing counts in bus clocks
  localparam logic [3:0] MARGIN_EXTRA = 4'h8;

  // ==========================================================================
  // Sequence progress and module state
  typedef enum logic [1:0] {
    STEP_IDLE = 2'b00,
    STEP_MODE = 2'b01,
    STEP_PROT = 2'b10,
    STEP_ADDR = 2'b11
  } seq_step_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    seq_step_t   step;
    logic [3:0]  protBits;
    logic [14:0] latchAddr;
    logic [63:0] pageBuf;
    logic        opBusy;
    logic [14:0] opPtr;
    logic [14:0] opEnd;
    logic        active;
    logic        writeQ;
    logic [15:0] addrQ;
    logic [3:0]  waitCnt;
    logic        hready;
    logic        hresp;
    logic [31:0] rdata;
    logic [1:0]  divCnt;
    logic        pumpTick;
  } flash_state_t;

endpackage : flash_ctrl_pkg

// >>> logic/flash_array_control_erase.sv
// Flash array control register, erase/program sequencer and AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps

module flash_array_control_erase
  import flash_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // AHB-Lite slave answer
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Array and charge pump controls
  output logic             pumpOn,
  output logic             highVoltArray,
  output logic             pumpClkEn,
  // Mode levels
  output logic             marginMode,
  output logic             programMode,
  output logic             eraseMode
);

  // ==========================================================================
  // Storage
  // Array cells, 32K bytes; not cleared by reset
  logic [7:0]   flashMem [0:32767];
  // Registered state and its next value
  flash_state_t st_r;
  flash_state_t st_nxt;
  // Cell read and write values
  logic [7:0]   memRd;
  logic [7:0]   memWr;

  // Array byte at the captured address
  assign memRd = flashMem[st_r.addrQ[14:0]];

  // ==========================================================================
  // Address decode helpers
  // True for any byte held in the array: user space, protect bytes, vectors
  function automatic logic isArray(input logic [15:0] a);
    logic inUser;
    logic inProt;
    logic inVect;
    inUser  = (a >= ARRAY_LO) && (a <= ARRAY_USER_HI);
    inProt  = (a >= PROTECT_LO) && (a <= PROTECT_HI);
    inVect  = (a >= VECTOR_LO) && (a <= VECTOR_HI);
    isArray = inUser || inProt || inVect;
  endfunction : isArray

  // Cared address bits of the erase region; zero bits are don't-care
  // The row is the smallest region, so the last code is the finest mask
  function automatic logic [14:0] eraseMask(input logic [1:0] blk);
    case (blk)
      // Whole array, no address bit compared
      2'b00:   eraseMask = MASK_FULL;
      // Half array, A14 compared
      2'b01:   eraseMask = MASK_HALF;
      // Eight rows, A14 to A9 compared
      2'b10:   eraseMask = MASK_EIGHT;
      // One row, A14 to A6 compared
      default: eraseMask = MASK_ROW;
    endcase
  endfunction : eraseMask

  // ==========================================================================
  // Next-state logic
  // Bus slave, control register, sequence tracker and cell walk in one pass
  // Reset comes last so it overrides every other assignment
  always_comb
  begin
    // Working copies of the control bits
    logic [7:0]  wd;
    logic        newPgm;
    logic        newErs;
    logic        newHv;
    logic        prevMode;
    // Region and protection helpers
    logic [14:0] mask;
    logic [14:0] regEnd;
    logic [14:0] protStart;
    logic        protAny;
    // Pump divider period
    logic [1:0]  divLast;

    // Locals first, so no path leaves one undriven
    divLast   = 2'd0;
    wd        = hwdata[7:0];
    // Operation bits default to their current values
    newPgm    = st_r.ctrl[PGM_BIT];
    newErs    = st_r.ctrl[ERASE_BIT];
    newHv     = st_r.ctrl[HIGH_VOLT_ENABLE_BIT];
    // An operation already selected before this write
    prevMode  = st_r.ctrl[PGM_BIT] | st_r.ctrl[ERASE_BIT];

    // Page mask while programming, erase-size mask otherwise
    mask      = st_r.ctrl[PGM_BIT] ? MASK_PAGE : eraseMask(st_r.ctrl[BLK_LSB +: 2]);
    // Last byte of the region around the captured address
    regEnd    = st_r.addrQ[14:0] | ~mask;

    // Lowest set protect bit gives the start of the locked range
    protAny   = |st_r.protBits;
    protStart = PROT_START3;
    if (st_r.protBits[0])
      protStart = PROT_START0;
    else if (st_r.protBits[1])
      protStart = PROT_START1;
    else if (st_r.protBits[2])
      protStart = PROT_START2;

    // Every field holds unless changed below
    st_nxt = st_r;

    // Charge pump clock enable divider
    case (st_r.ctrl[DIV_LSB +: 2])
      // Tick every cycle
      2'b00:   divLast = 2'd0;
      // Tick every second cycle
      2'b01:   divLast = 2'd1;
      2'b10:   divLast = 2'd1;
      // Tick every fourth cycle
      default: divLast = 2'd3;
    endcase
    // Tick on the first count of each divide period
    st_nxt.pumpTick = (st_r.divCnt == 2'd0);
    // Count wraps at the last value of the period
    st_nxt.divCnt   = (st_r.divCnt >= divLast) ? 2'd0 : st_r.divCnt + 2'd1;

    // High-voltage walk over the selected region
    if (st_r.opBusy)
    begin
      // Walk ends at the region's last byte,
      // or early when software drops the enable
      if (!st_r.ctrl[HIGH_VOLT_ENABLE_BIT] || st_r.opPtr == st_r.opEnd)
        st_nxt.opBusy = 1'b0;
      // Step one byte per clock
      else
        st_nxt.opPtr = st_r.opPtr + 15'd1;
    end

    // Address phase capture
    // Taken only when the slave is ready, so never inside a data phase
    if (hsel && htrans[1] && hready)
    begin
      // One wait state at least; ready drops next cycle
      st_nxt.active  = 1'b1;
      st_nxt.hready  = 1'b0;
      st_nxt.writeQ  = hwrite;
      st_nxt.addrQ   = haddr[17:2];
      // Margin-mode array reads wait eight more cycles
      st_nxt.waitCnt = (!hwrite && st_r.ctrl[MARGIN_BIT] && isArray(haddr[17:2]) &&
                        haddr[31:18] == 14'h0000) ? MARGIN_EXTRA : 4'h0;
      // Above the mapped window: decode as an empty slot
      if (haddr[31:18] != 14'h0000)
        st_nxt.addrQ = 16'h0000;
    end
    else if (st_r.active && st_r.waitCnt != 4'h0)
    begin
      // Stretch count runs down before the data phase ends
      st_nxt.waitCnt = st_r.waitCnt - 4'h1;
    end
    else if (st_r.active)
    begin
      // Data phase completes
      st_nxt.active = 1'b0;
      st_nxt.hready = 1'b1;
      // Unmapped reads and all writes return zero
      st_nxt.rdata  = 32'h0000_0000;
      // Reads: control, array, protect capture
      if (!st_r.writeQ)
      begin
        // Control register or array byte on the low lane
        if (st_r.addrQ == CTRL_INDEX)
          st_nxt.rdata = {24'h00_0000, st_r.ctrl};
        else if (isArray(st_r.addrQ))
          st_nxt.rdata = {24'h00_0000, memRd};
        // Protect byte read arms the sequence
        if (st_r.addrQ == PROTECT_LO && st_r.step == STEP_MODE)
        begin
          // Low four bits hold the lock flags
          st_nxt.protBits = memRd[3:0];
          st_nxt.step     = STEP_PROT;
        end
      end
      // Control register write
      else if (st_r.addrQ == CTRL_INDEX)
      begin
        // Divider and size fields take the written value
        st_nxt.ctrl[DIV_LSB +: 2] = wd[DIV_LSB +: 2];
        st_nxt.ctrl[BLK_LSB +: 2] = wd[BLK_LSB +: 2];
        if (!(wd[PGM_BIT] && wd[ERASE_BIT]))
        begin
          newPgm = wd[PGM_BIT];
          newErs = wd[ERASE_BIT];
        end
        // Interlocked operation bits
        st_nxt.ctrl[PGM_BIT]   = newPgm;
        st_nxt.ctrl[ERASE_BIT] = newErs;
        // Enable accepted only after the address latch, same operation kept
        if (!wd[HIGH_VOLT_ENABLE_BIT])
          newHv = 1'b0;
        else if (!st_r.ctrl[HIGH_VOLT_ENABLE_BIT] && (newPgm || newErs) && st_r.step == STEP_ADDR &&
                 newPgm == st_r.ctrl[PGM_BIT] && newErs == st_r.ctrl[ERASE_BIT])
        begin
          newHv          = 1'b1;
          // Start the walk over the cared region
          st_nxt.opBusy  = 1'b1;
          st_nxt.opPtr   = st_r.latchAddr & mask;
          st_nxt.opEnd   = st_r.latchAddr | ~mask;
        end
        // No high voltage once neither operation stays selected
        if (!(newPgm || newErs))
          newHv = 1'b0;
        st_nxt.ctrl[HIGH_VOLT_ENABLE_BIT]   = newHv;
        // Margin refused while the enable is on or being set
        st_nxt.ctrl[MARGIN_BIT] = wd[MARGIN_BIT] && !st_r.ctrl[HIGH_VOLT_ENABLE_BIT] && !newHv;
        // Sequence follows the selected operation
        // Leaving both operations off abandons the sequence
        if (!(newPgm || newErs))
          st_nxt.step = STEP_IDLE;
        // A new or changed operation needs a fresh protect read
        else if (!prevMode || newPgm != st_r.ctrl[PGM_BIT])
        begin
          st_nxt.step    = STEP_MODE;
          // Fresh page buffer for a new program
          st_nxt.pageBuf = 64'h0000_0000_0000_0000;
        end
      end
      // Array write inside the sequence
      else if (isArray(st_r.addrQ) && !st_r.ctrl[HIGH_VOLT_ENABLE_BIT] &&
               (st_r.step == STEP_PROT ||
                (st_r.step == STEP_ADDR && st_r.ctrl[PGM_BIT])))
      begin
        // Address latch; program also buffers the page byte
        if (st_r.step == STEP_PROT)
        begin
          // Cared bits are applied by the mask at enable time
          st_nxt.latchAddr = st_r.addrQ[14:0];
          st_nxt.step      = STEP_ADDR;
          // Region reaching a locked range drops the operation
          if (protAny && regEnd >= protStart)
          begin
            st_nxt.ctrl[PGM_BIT]   = 1'b0;
            st_nxt.ctrl[ERASE_BIT] = 1'b0;
            st_nxt.step            = STEP_IDLE;
          end
        end
        // Only bytes of the latched page are buffered
        if (st_r.ctrl[PGM_BIT] && (st_r.step == STEP_PROT ||
            (st_r.addrQ[14:0] & MASK_PAGE) == (st_r.latchAddr & MASK_PAGE)))
          st_nxt.pageBuf[st_r.addrQ[2:0] * 8 +: 8] = wd;
      end
    end

    // Synchronous reset overrides every update above
    if (rst)
    begin
      st_nxt        = '0;
      // Control register and sequence start clear
      st_nxt.ctrl   = CTRL_RESET;
      st_nxt.step   = STEP_IDLE;
      // Ready high so the first transfer is taken at once
      st_nxt.hready = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  // Whole state advances together on each edge
  always_ff @(posedge core_clk)
  begin
    st_r <= st_nxt;
  end

  // ==========================================================================
  // Array cell update under high voltage
  // Erase clears a cell; program only ever sets bits
  assign memWr = st_r.ctrl[ERASE_BIT] ? 8'h00 :
                 (flashMem[st_r.opPtr] | st_r.pageBuf[st_r.opPtr[2:0] * 8 +: 8]);

  // Plain clocked process: cells may also be preloaded from outside it
  always @(posedge core_clk)
  begin
    // Cells change only while the walk runs under high voltage
    if (!rst && st_r.opBusy && st_r.ctrl[HIGH_VOLT_ENABLE_BIT])
      flashMem[st_r.opPtr] <= memWr;
  end

  // ==========================================================================
  // Outputs
  // Bus answer
  assign hreadyout     = st_r.hready;
  assign hresp         = st_r.hresp;
  assign hrdata        = st_r.rdata;
  // Pump and array voltage follow the enable bit
  assign pumpOn        = st_r.ctrl[HIGH_VOLT_ENABLE_BIT];
  assign highVoltArray = st_r.ctrl[HIGH_VOLT_ENABLE_BIT];
  // Pump clock enable and mode levels
  assign pumpClkEn     = st_r.pumpTick;
  assign marginMode    = st_r.ctrl[MARGIN_BIT];
  // Interlocked operation levels
  assign programMode   = st_r.ctrl[PGM_BIT];
  assign eraseMode     = st_r.ctrl[ERASE_BIT];

endmodule : flash_array_control_erase

// >>> sim/flash_ctrl_checker_assertions.sv
// Port assertions for the flash control block
`timescale 1ns/1ps
module flash_ctrl_checker (
  // Clock, reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Array
  input wire logic        pumpOn,
  input wire logic        highVoltArray,
  input wire logic        pumpClkEn,
  input wire logic        marginMode,
  input wire logic        programMode,
  input wire logic        eraseMode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // =========
  // Taken transfer, stretched array read
  logic tk;
  logic slow;
  assign tk = hsel && htrans[1] && hready;
  assign slow = !hwrite && marginMode &&
                ((haddr[31:2] >= 30'h8000 && haddr[31:2] <= 30'hFDFF) ||
                 (haddr[31:2] >= 30'hFF80 && haddr[31:2] <= 30'hFF81) ||
                 (haddr[31:2] >= 30'hFFCC && haddr[31:2] <= 30'hFFFF));
  pump_tracks_a: assert property (pumpOn == highVoltArray)
    else $error("pump and array voltage differ");
  hv_needs_op_a: assert property (pumpOn |-> programMode || eraseMode)
    else $error("high voltage without operation");
  op_exclusive_a: assert property (!(programMode && eraseMode))
    else $error("program and erase both set");
  margin_no_hv_a: assert property ($rose(marginMode) |-> !pumpOn)
    else $error("margin set under high voltage");
  pump_div_a: assert property (not (!pumpClkEn [*5]))
    else $error("pump clock gap too long");
  write_wait_a: assert property (tk && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("write latency wrong");
  read_wait_a: assert property (tk && !hwrite && !slow |=> !hreadyout ##1 hreadyout)
    else $error("read latency wrong");
  margin_wait_a: assert property (tk && slow |=> !hreadyout [*8] ##1 !hreadyout ##1 hreadyout)
    else $error("margin read latency wrong");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule : flash_ctrl_checker

bind flash_array_control_erase flash_ctrl_checker chk (.core_clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .pumpOn, .highVoltArray, .pumpClkEn,
  .marginMode, .programMode, .eraseMode);

// >>> sim/cpu_bus_model.sv
// Bus master standing in for CPU software
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock
  input  wire logic        core_clk,
  // Request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  // =========
  // One word transfer, edges of wait counted; steps issued in order
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output int lat);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {14'h0000, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    lat = 0;
    do
    begin
      @(posedge core_clk);
      lat++;
    end
    while (hready !== 1'b1);
    rd = hrdata[7:0];
    hsel <= 1'b0;
  endtask : xfer
endmodule : cpu_bus_model

// >>> sim/tb_top.sv
// Self-checking bench for the flash control block
`timescale 1ns/1ps
module tb_top;
  import flash_ctrl_pkg::*;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, pumpOn, highVoltArray, pumpClkEn;
  logic marginMode, programMode, eraseMode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] rv, n;
  int fails = 0, checksDone = 0, lat;
  flash_array_control_erase dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pumpOn, .highVoltArray,
    .pumpClkEn, .marginMode, .programMode, .eraseMode);
  cpu_bus_model cpu (.core_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);
  // =========
  // Helpers
  task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, rv, lat);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    cpu.xfer(1'b0, a, 8'h00, rv, lat);
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // =========
  // Scenarios
  task automatic t_regs();
    rd(CTRL_INDEX);
    check("ctrl reset", CTRL_RESET, rv);
    rd(16'hFE0C);
    check("unmapped", 8'h00, rv);
    wr(CTRL_INDEX, 8'h03);
    rd(CTRL_INDEX);
    check("both ops", 8'h00, rv);
    wr(CTRL_INDEX, 8'h01);
    wr(CTRL_INDEX, 8'h03);
    rd(CTRL_INDEX);
    check("ops kept", 8'h01, rv);
    check("program out", 8'h01, {7'h00, programMode});
  endtask : t_regs
  task automatic t_div();
    for (int d = 0; d < 4; d++)
    begin
      wr(CTRL_INDEX, 8'(d << DIV_LSB));
      repeat (4) @(posedge core_clk);
      n = 0;
      repeat (16)
      begin
        @(posedge core_clk);
        n += {7'h00, pumpClkEn};
      end
      check("pump ticks", (d == 0) ? 8'h10 : (d == 3) ? 8'h04 : 8'h08, n);
    end
  endtask : t_div
  task automatic t_erase();
    for (int i = 0; i < 192; i++) dut.flashMem[i] = 8'hFF;
    wr(CTRL_INDEX, 8'h32);
    rd(PROTECT_LO);
    wr(16'h8047, 8'h5A);
    wr(CTRL_INDEX, 8'h3A);
    check("hv on", 8'h03, {6'h00, pumpOn, highVoltArray});
    repeat (80) @(posedge core_clk);
    wr(CTRL_INDEX, 8'h32);
    check("hv off", 8'h00, {6'h00, pumpOn, highVoltArray});
    wr(CTRL_INDEX, 8'h30);
    rd(16'h803F);
    check("row0 kept", 8'hFF, rv);
    rd(16'h8040);
    check("row1 first", 8'h00, rv);
    rd(16'h807F);
    check("row1 last", 8'h00, rv);
    rd(16'h8080);
    check("row2 kept", 8'hFF, rv);
  endtask : t_erase
  task automatic t_protect();
    dut.flashMem[15'h7F80] = 8'h08;
    wr(CTRL_INDEX, 8'h32);
    rd(PROTECT_LO);
    wr(16'hC000, 8'h00);
    rd(CTRL_INDEX);
    check("erase cleared", 8'h30, rv);
    wr(CTRL_INDEX, 8'h38);
    rd(CTRL_INDEX);
    check("hv refused", 8'h30, rv);
    dut.flashMem[15'h7F80] = 8'h00;
    wr(CTRL_INDEX, 8'h00);
  endtask : t_protect
  task automatic t_program();
    wr(CTRL_INDEX, 8'h01);
    rd(PROTECT_LO);
    for (int i = 0; i < 8; i++) wr(16'h8100 + 16'(i), 8'hA0 + 8'(i));
    wr(CTRL_INDEX, 8'h09);
    wr(CTRL_INDEX, 8'h0D);
    rd(CTRL_INDEX);
    check("margin refused", 8'h09, rv);
    repeat (16) @(posedge core_clk);
    wr(CTRL_INDEX, 8'h01);
    wr(CTRL_INDEX, 8'h05);
    rd(16'h8107);
    check("programmed", 8'hA7, rv);
    check("margin wait", 8'h0A, 8'(lat));
    check("margin out", 8'h01, {7'h00, marginMode});
    wr(CTRL_INDEX, 8'h00);
    rd(16'h8107);
    check("normal wait", 8'h02, 8'(lat));
  endtask : t_program
  // =========
  // Clock, watchdog, main sequence
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    fails++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    for (int i = 0; i < 32768; i++) dut.flashMem[i] = 8'h00;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_div();
    t_erase();
    t_protect();
    t_program();
    close_out();
  end
endmodule : tb_top
